/* File: common/rca_pkg.sv */
// package: constants, types and register map of the remote control arbiter
package rca_pkg;

    // ==========================================
    // register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_CONFIG    = 8'h00;
    localparam logic [7:0] OFS_PANEL_SET = 8'h04;
    localparam logic [7:0] OFS_LIMITS    = 8'h08;
    localparam logic [7:0] OFS_STATUS    = 8'h0C;
    localparam logic [7:0] OFS_ACTIVE    = 8'h10;
    localparam logic [7:0] OFS_HOST_CMD  = 8'h14;

    // ==========================================
    // config field positions
    localparam int CFG_ALLOW_REMOTE = 0;
    localparam int CFG_RANGE_10V    = 1;
    localparam int CFG_PF_STATE_ON  = 2;
    localparam int CFG_OT_STATE_ON  = 3;
    localparam int CFG_MASK_LSB     = 8;
    localparam logic [31:0] CFG_RESET = 32'h0000_3F01;

    // host command bits (write strobes)
    localparam int HCMD_REQUEST = 0;
    localparam int HCMD_RELEASE = 1;

    // ==========================================
    // set values: 16-bit fractions, full scale = 100 %
    localparam int SV_W = 16;
    localparam logic [15:0] SV_FULL     = 16'hFFFF;
    // adc code at 5 V when the adc spans 10 V
    localparam logic [15:0] ADC_HALF    = 16'h7FFF;

    // alarm indices
    localparam int AL_N   = 6;
    localparam int AL_MSP = 0;
    localparam int AL_OV  = 1;
    localparam int AL_OC  = 2;
    localparam int AL_OP  = 3;
    localparam int AL_PF  = 4;
    localparam int AL_OT  = 5;

    // ==========================================
    // timing
    localparam int  CLK_HZ        = 125_000_000;
    localparam int  SAMPLE_HZ     = 500;
    localparam int  SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
    localparam int  ACK_LOW_MS    = 50;
    localparam int  ACK_LOW_SAMPLES = (ACK_LOW_MS * SAMPLE_HZ + 999) / 1000;

    typedef enum logic [1:0] {
        RCA_LOC_NONE,
        RCA_LOC_LOCAL,
        RCA_LOC_ANALOG,
        RCA_LOC_DIGITAL
    } rca_loc_t;

    typedef struct packed {
        logic [15:0] voltage;
        logic [15:0] current;
        logic [15:0] power;
        logic [15:0] resistance;
    } rca_setv_t;

endpackage

/* File: hdl/rca_ack_detect.sv */
// module: high-low-high acknowledge detector on the sampled input switch pin
`timescale 1ns/1ps
module rca_ack_detect #(
    parameter int MIN_LOW = rca_pkg::ACK_LOW_SAMPLES
) (
    input  wire logic core_clk_in,
    input  wire logic reset_n_in,
    input  wire logic sample_in,
    input  wire logic level_in,
    output logic      ack_out
);
    logic        prev_reg;
    logic [15:0] low_cnt_reg;
    logic        ack_reg;

    assign ack_out = ack_reg;

    // ==========================================
    // low phase counted in samples
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            prev_reg    <= 1'b1;
            low_cnt_reg <= 16'h0000;
            ack_reg     <= 1'b0;
        end else begin
            ack_reg <= 1'b0;
            if (sample_in) begin
                prev_reg <= level_in;
                if (!level_in) begin
                    if (low_cnt_reg != 16'hFFFF)
                        low_cnt_reg <= low_cnt_reg + 16'h0001;
                end else begin
                    // rising edge ends a long enough low phase
                    if (!prev_reg && low_cnt_reg >= 16'(MIN_LOW))
                        ack_reg <= 1'b1;
                    low_cnt_reg <= 16'h0000;
                end
            end
        end
    end
endmodule

/* File: hdl/rca_top.sv */
// module: control location arbiter, analog set values and alarm latching
// Behaviour
// (RQ1) no remote active means manual, requests allowed
// (RQ2) allow-remote setting; inhibited enters local state
// (RQ3) local state locks out all remote control
// (RQ4) local ends digital control; host must re-request
// (RQ5) local suspends analog; resumes if pin requests
// (RQ6) digital request during analog control gets error
// (RQ7) analog request ignored while digital holds control
// (RQ8) analog needs select pin; input switch always honoured
// (RQ9) voltage, current, power all from port together
// (RQ10) displayed set values follow port under analog
// (RQ11) range setting picks 5 V or 10 V
// (RQ12) over-range input clipped to full scale
// (RQ13) protection thresholds never taken from port
// (RQ14) controller ignores status outputs during start phase
// (RQ15) controller drives all set inputs defined
// (RQ16) alarm switches input off, reported on outputs; MSP alarm reaches neither alarms1 nor alarms2
// (RQ17) reported alarms selectable by configuration
// (RQ18) latched alarms need high-low-high ack, 50 ms low
// (RQ19) power fail, overtemp ack only if state off
// (RQ20) pins and set values sampled at 500 Hz
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
module rca_top #(
    parameter int SAMPLE_CYCLES = rca_pkg::SAMPLE_CYCLES,
    parameter int START_SAMPLES = 4
) (
    input  wire logic                  core_clk_in,
    input  wire logic                  reset_n_in,
    input  wire logic [7:0]            addr_in,
    input  wire logic [31:0]           wdata_in,
    input  wire logic                  wr_in,
    input  wire logic                  rd_in,
    output logic      [31:0]           rdata_out,
    input  wire logic                  ext_select_n_in,
    input  wire logic                  input_switch_pin_in,
    input  wire logic                  r_mode_n_in,
    input  wire rca_pkg::rca_setv_t    analog_control_port_in,
    input  wire logic [5:0]            alarm_event_in,
    input  wire logic                  constant_voltage_state_in,
    output rca_pkg::rca_setv_t         active_setv_out,
    output logic                       dc_input_on_out,
    output logic [1:0]                 location_out,
    output logic                       host_error_out,
    output logic                       alarms1_out,
    output logic                       alarms2_out,
    output logic                       cv_status_n_out,
    output logic                       range_10v_out,
    output logic                       status_valid_out,
    output logic [31:0]                limits_out
);
    // ==========================================
    // declarations
    logic [31:0]        cfg_reg, limits_reg, rdata_reg, tick_cnt_reg;
    rca_pkg::rca_setv_t panel_reg, port_reg, active_reg;
    rca_pkg::rca_loc_t  loc_reg;
    logic [2:0]         sel_sync_reg, sw_sync_reg;
    logic [1:0]         rm_sync_reg;
    logic [5:0]         al_sync1_reg, al_sync2_reg, alarm_reg, needs_ack, reported;
    logic [7:0]         start_cnt_reg;
    logic               host_active_reg, host_error_reg, sel_smp_reg, sw_smp_reg, rm_smp_reg;
    logic               cv_sync1_reg, cv_sync2_reg, tick_reg, ready_reg, dc_on_reg, sw_prev_reg;
    logic               alarms1_reg, alarms2_reg, cv_reg, ack, wr_cmd, host_req, host_rel, allow;

    assign allow    = cfg_reg[rca_pkg::CFG_ALLOW_REMOTE];
    assign wr_cmd   = wr_in && addr_in == rca_pkg::OFS_HOST_CMD;
    assign host_req = wr_cmd && wdata_in[rca_pkg::HCMD_REQUEST];
    assign host_rel = wr_cmd && wdata_in[rca_pkg::HCMD_RELEASE];

    // ==========================================
    // scaling: adc spans 0..10 V, 5 V range doubles and clips
    function automatic logic [15:0] scale_sv(input logic [15:0] raw, input logic r10);
        if (r10)
            scale_sv = raw; // RQ11
        else if (raw > rca_pkg::ADC_HALF)
            scale_sv = rca_pkg::SV_FULL; // RQ12
        else
            scale_sv = {raw[14:0], 1'b0}; // RQ11
    endfunction

    // ==========================================
    // sample tick and start phase
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg     <= 1'b0;
        end else if (tick_cnt_reg == 32'(SAMPLE_CYCLES - 1)) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg     <= 1'b1; // RQ20
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
            tick_reg     <= 1'b0;
        end
    end

    // status undefined in start phase
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            start_cnt_reg <= 8'h00;
            ready_reg     <= 1'b0;
        end else if (tick_reg && !ready_reg) begin
            start_cnt_reg <= start_cnt_reg + 8'h01;
            ready_reg     <= start_cnt_reg == 8'(START_SAMPLES - 1); // RQ14
        end
    end

    // ==========================================
    // pin synchronisers, then sampled at the tick
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            sel_sync_reg <= 3'h7;
            sw_sync_reg  <= 3'h7;
            rm_sync_reg  <= 2'h3;
            sel_smp_reg  <= 1'b1;
            sw_smp_reg   <= 1'b1;
            rm_smp_reg   <= 1'b1;
            port_reg     <= '0;
            al_sync1_reg <= 6'h00;
            al_sync2_reg <= 6'h00;
            cv_sync1_reg <= 1'b0;
            cv_sync2_reg <= 1'b0;
        end else begin
            sel_sync_reg <= {sel_sync_reg[1:0], ext_select_n_in};
            sw_sync_reg  <= {sw_sync_reg[1:0], input_switch_pin_in};
            rm_sync_reg  <= {rm_sync_reg[0], r_mode_n_in};
            al_sync1_reg <= alarm_event_in;
            al_sync2_reg <= al_sync1_reg;
            cv_sync1_reg <= constant_voltage_state_in;
            cv_sync2_reg <= cv_sync1_reg;
            if (tick_reg) begin
                sel_smp_reg <= sel_sync_reg[1]; // RQ20
                sw_smp_reg  <= sw_sync_reg[1];
                rm_smp_reg  <= rm_sync_reg[1];
                // adc holds words between conversions
                port_reg    <= analog_control_port_in; // RQ20
            end
        end
    end

    // ==========================================
    // control location
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            loc_reg         <= rca_pkg::RCA_LOC_NONE;
            host_active_reg <= 1'b0;
            host_error_reg  <= 1'b0;
        end else begin
            host_error_reg <= 1'b0;
            if (!allow) begin
                loc_reg         <= rca_pkg::RCA_LOC_LOCAL; // RQ2 RQ3
                host_active_reg <= 1'b0; // RQ4
                host_error_reg  <= host_req; // RQ3
            end else begin
                case (loc_reg)
                    rca_pkg::RCA_LOC_NONE, rca_pkg::RCA_LOC_LOCAL: begin
                        // analog resumes if pin still low
                        if (!sel_smp_reg)
                            loc_reg <= rca_pkg::RCA_LOC_ANALOG; // RQ5 RQ8
                        else if (host_req) begin
                            loc_reg         <= rca_pkg::RCA_LOC_DIGITAL; // RQ1
                            host_active_reg <= 1'b1;
                        end else
                            loc_reg <= rca_pkg::RCA_LOC_NONE; // RQ1
                        if (!sel_smp_reg && host_req)
                            host_error_reg <= 1'b1; // RQ6
                    end
                    rca_pkg::RCA_LOC_ANALOG: begin
                        host_error_reg <= host_req; // RQ6
                        if (sel_smp_reg)
                            loc_reg <= rca_pkg::RCA_LOC_NONE;
                    end
                    rca_pkg::RCA_LOC_DIGITAL: begin
                        // select pin ignored here
                        if (host_rel) begin
                            loc_reg         <= rca_pkg::RCA_LOC_NONE; // RQ7
                            host_active_reg <= 1'b0;
                        end
                    end
                    default: loc_reg <= rca_pkg::RCA_LOC_NONE;
                endcase
            end
        end
    end

    // ==========================================
    // active set values
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            active_reg <= '0;
        end else if (loc_reg == rca_pkg::RCA_LOC_ANALOG) begin
            // all three from the port, never mixed with panel
            active_reg.voltage <= scale_sv(port_reg.voltage, range_10v_out); // RQ9 RQ10
            active_reg.current <= scale_sv(port_reg.current, range_10v_out); // RQ9
            active_reg.power   <= scale_sv(port_reg.power, range_10v_out); // RQ9
            if (!rm_smp_reg)
                active_reg.resistance <= scale_sv(port_reg.resistance, range_10v_out);
            else
                active_reg.resistance <= panel_reg.resistance;
        end else begin
            active_reg <= panel_reg;
        end
    end

    // ==========================================
    // alarms and dc input
    rca_ack_detect u_ack (
        .core_clk_in (core_clk_in),
        .reset_n_in  (reset_n_in),
        .sample_in   (tick_reg),
        .level_in    (sw_smp_reg),
        .ack_out     (ack)
    );

    assign needs_ack = {~cfg_reg[rca_pkg::CFG_OT_STATE_ON], ~cfg_reg[rca_pkg::CFG_PF_STATE_ON],
                        4'hF}; // RQ18 RQ19
    assign reported  = alarm_reg & cfg_reg[rca_pkg::CFG_MASK_LSB +: rca_pkg::AL_N]; // RQ17

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            alarm_reg <= 6'h00;
        end else begin
            // new events win over acknowledge; self-clearing alarms follow the cause
            alarm_reg <= al_sync2_reg | (alarm_reg & (ack ? ~needs_ack : needs_ack) &
                         (needs_ack | al_sync2_reg)); // RQ18 RQ19
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            dc_on_reg   <= 1'b0;
            sw_prev_reg <= 1'b1;
        end else begin
            sw_prev_reg <= sw_smp_reg;
            if (|alarm_reg)
                dc_on_reg <= 1'b0; // RQ16
            else if (sw_smp_reg != sw_prev_reg)
                dc_on_reg <= sw_smp_reg; // RQ8
            else if (wr_in && addr_in == rca_pkg::OFS_ACTIVE &&
                     loc_reg != rca_pkg::RCA_LOC_ANALOG)
                dc_on_reg <= wdata_in[0];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            alarms1_reg <= 1'b0;
            alarms2_reg <= 1'b0;
            cv_reg      <= 1'b1;
        end else begin
            alarms1_reg <= reported[rca_pkg::AL_PF] | reported[rca_pkg::AL_OT]; // RQ16
            alarms2_reg <= reported[rca_pkg::AL_OV] | reported[rca_pkg::AL_OC] | reported[rca_pkg::AL_OP];
            cv_reg      <= ~cv_sync2_reg;
        end
    end

    // ==========================================
    // register bus
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            cfg_reg    <= rca_pkg::CFG_RESET;
            limits_reg <= 32'h0000_0000;
            panel_reg  <= '0;
        end else if (wr_in) begin
            case (addr_in)
                rca_pkg::OFS_CONFIG:    cfg_reg <= wdata_in;
                // thresholds only from the bus, never the port
                rca_pkg::OFS_LIMITS:    limits_reg <= wdata_in; // RQ13
                rca_pkg::OFS_PANEL_SET: begin
                    // ignored under analog control
                    if (loc_reg != rca_pkg::RCA_LOC_ANALOG)
                        panel_reg <= {wdata_in, wdata_in};
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd_in) begin
            case (addr_in)
                rca_pkg::OFS_CONFIG:    rdata_reg <= cfg_reg;
                rca_pkg::OFS_PANEL_SET: rdata_reg <= {active_reg.current, active_reg.voltage};
                rca_pkg::OFS_LIMITS:    rdata_reg <= limits_reg;
                rca_pkg::OFS_STATUS:    rdata_reg <= {16'h0000, 2'h0, alarm_reg, 3'h0, ready_reg,
                                                      host_active_reg, loc_reg, dc_on_reg};
                rca_pkg::OFS_ACTIVE:    rdata_reg <= {active_reg.resistance, active_reg.power};
                default:                rdata_reg <= 32'h0000_0000;
            endcase
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign rdata_out        = rdata_reg;
    assign active_setv_out  = active_reg;
    assign dc_input_on_out  = dc_on_reg;
    assign location_out     = loc_reg;
    assign host_error_out   = host_error_reg;
    assign alarms1_out      = alarms1_reg;
    assign alarms2_out      = alarms2_reg;
    assign cv_status_n_out  = cv_reg;
    assign range_10v_out    = cfg_reg[rca_pkg::CFG_RANGE_10V];
    assign status_valid_out = ready_reg;
    assign limits_out       = limits_reg;
endmodule

/* File: tb/rca_ext_ctrl.sv */
// partner model: external controller on the analog control port
`timescale 1ns/1ps
module rca_ext_ctrl (
    input  wire logic               core_clk_in,
    input  wire logic               sel_req_in,
    input  wire logic               sw_req_in,
    input  wire logic               rmode_req_in,
    input  wire rca_pkg::rca_setv_t setv_req_in,
    input  wire logic               status_valid_in,
    input  wire logic               alarms2_in,
    output logic                    ext_select_n_out,
    output logic                    input_switch_pin_out,
    output logic                    r_mode_n_out,
    output rca_pkg::rca_setv_t      port_out,
    output logic                    alarm_seen_out
);
    // ==========================================
    // pins
    initial begin
        ext_select_n_out = 1'b1;
        input_switch_pin_out = 1'b1;
        r_mode_n_out = 1'b1;
        port_out = '0;
        alarm_seen_out = 1'b0;
    end
    always @(posedge core_clk_in) begin
        ext_select_n_out <= ~sel_req_in;
        input_switch_pin_out <= sw_req_in;
        r_mode_n_out <= ~rmode_req_in;
    end
    // ==========================================
    // set values: three move as one, unused resistance toggles to expose misuse
    always @(posedge core_clk_in) begin
        port_out.voltage <= setv_req_in.voltage;
        port_out.current <= setv_req_in.current;
        port_out.power <= setv_req_in.power;
        port_out.resistance <= rmode_req_in ? setv_req_in.resistance : ~port_out.resistance;
    end
    // ==========================================
    // status undefined in start phase, so gated
    always @(posedge core_clk_in) begin
        alarm_seen_out <= status_valid_in & alarms2_in;
    end
endmodule

/* File: tb/rca_top_monitor.sv */
// checker: bus, arbitration and alarm relations at the arbiter ports
`timescale 1ns/1ps
module rca_top_monitor #(
    parameter int SAMPLE_CYCLES = 10
) (
    input wire logic        core_clk_in,
    input wire logic        reset_n_in,
    input wire logic [7:0]  addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic [5:0]  alarm_event_in,
    input wire logic        dc_input_on_out,
    input wire logic [1:0]  location_out,
    input wire logic        host_error_out,
    input wire logic        alarms2_out,
    input wire logic        range_10v_out,
    input wire logic [31:0] limits_out
);
    // sync flops plus four sample ticks, with margin
    localparam int WIN = 4 * SAMPLE_CYCLES + 8;
    wire hcmd = wr_in && addr_in == rca_pkg::OFS_HOST_CMD;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    // ==========================================
    // sequences
    sequence s_host_req;
        hcmd && wdata_in[rca_pkg::HCMD_REQUEST];
    endsequence
    sequence s_ov_rise;
        $rose(alarm_event_in[rca_pkg::AL_OV]);
    endsequence
    // ==========================================
    // assertions
    a_refuse_under_analog: assert property (s_host_req ##0 location_out == rca_pkg::RCA_LOC_ANALOG
        |=> host_error_out) else $error("host request under analog control not refused");
    a_error_has_cause: assert property (host_error_out
        |-> $past(hcmd)) else $error("error pulse without host write");
    a_digital_blocks_analog: assert property (location_out == rca_pkg::RCA_LOC_DIGITAL
        |=> location_out != rca_pkg::RCA_LOC_ANALOG) else $error("analog took over from digital");
    a_local_ends_digital: assert property (location_out == rca_pkg::RCA_LOC_LOCAL
        && !hcmd
        |=> location_out != rca_pkg::RCA_LOC_DIGITAL) else $error("digital resumed without request");
    a_status_read: assert property (rd_in && addr_in == rca_pkg::OFS_STATUS
        |=> rdata_out[2:1] == $past(location_out) && rdata_out[0] == $past(dc_input_on_out))
        else $error("status read wrong");
    a_rdata_idle_zero: assert property (!$past(rd_in) |-> rdata_out == 32'h0000_0000)
        else $error("read data outside answer cycle");
    a_range_from_cfg: assert property (wr_in && addr_in == rca_pkg::OFS_CONFIG
        |=> range_10v_out == $past(wdata_in[rca_pkg::CFG_RANGE_10V])) else $error("range bit wrong");
    a_limits_bus_only: assert property (!(wr_in && addr_in == rca_pkg::OFS_LIMITS)
        |=> $stable(limits_out)) else $error("limits changed without bus write");
    a_limits_written: assert property (wr_in && addr_in == rca_pkg::OFS_LIMITS
        |=> limits_out == $past(wdata_in)) else $error("limits write lost");
    a_alarm_input_off: assert property (s_ov_rise |-> ##[0:WIN] !dc_input_on_out)
        else $error("alarm left input on");
    a_alarm_reported: assert property (s_ov_rise |-> ##[0:WIN] alarms2_out)
        else $error("alarm not reported");
endmodule
bind rca_top rca_top_monitor #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_mon (.core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .alarm_event_in(alarm_event_in), .dc_input_on_out(dc_input_on_out),
    .location_out(location_out), .host_error_out(host_error_out), .alarms2_out(alarms2_out),
    .range_10v_out(range_10v_out), .limits_out(limits_out));

/* File: tb/tb_rca_top.sv */
// testbench: arbitration, analog scaling and alarm latching of the arbiter
`timescale 1ns/1ps
module tb_rca_top;
    // ==========================================
    // signals
    localparam int SC = 10;
    logic               core_clk_in = 1'b0;
    logic               reset_n_in  = 1'b0;
    logic [7:0]         addr        = 8'h00;
    logic [31:0]        wdata       = 32'h0000_0000;
    logic               wr          = 1'b0;
    logic               rd          = 1'b0;
    logic               sel_req     = 1'b0;
    logic               sw_req      = 1'b1;
    logic [5:0]         alarm_ev    = 6'h00;
    logic [31:0]        seed        = 32'hEEC12ECC;
    rca_pkg::rca_setv_t setv        = '0;
    rca_pkg::rca_setv_t port, act;
    logic [31:0]        rdata, limits;
    logic [1:0]         loc;
    logic [15:0]        v;
    logic               sel_n, sw, rmode_n, dc_on, host_err, al1, al2, r10, valid, seen;
    int                 fails = 0, compares = 0, cycles = 0;
    always #4 core_clk_in = ~core_clk_in;
    rca_ext_ctrl ext (.core_clk_in(core_clk_in), .sel_req_in(sel_req), .sw_req_in(sw_req),
        .rmode_req_in(1'b0), .setv_req_in(setv), .status_valid_in(valid), .alarms2_in(al2),
        .ext_select_n_out(sel_n), .input_switch_pin_out(sw), .r_mode_n_out(rmode_n),
        .port_out(port), .alarm_seen_out(seen));
    rca_top #(.SAMPLE_CYCLES(SC), .START_SAMPLES(4)) dut (.core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .ext_select_n_in(sel_n), .input_switch_pin_in(sw), .r_mode_n_in(rmode_n),
        .analog_control_port_in(port), .alarm_event_in(alarm_ev), .constant_voltage_state_in(1'b0),
        .active_setv_out(act), .dc_input_on_out(dc_on), .location_out(loc), .host_error_out(host_err),
        .alarms1_out(al1), .alarms2_out(al2), .cv_status_n_out(), .range_10v_out(r10),
        .status_valid_out(valid), .limits_out(limits));
    // ==========================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [15:0] scale(input logic [15:0] c, input logic r);
        if (r) return c;
        return (c > rca_pkg::ADC_HALF) ? 16'hFFFF : {c[14:0], 1'b0};
    endfunction
    task automatic summarize();
        if (fails == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [63:0] seen_v, input logic [63:0] exp_v);
        compares++;
        if (seen_v !== exp_v) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
        end
    endtask
    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk_in);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd32(input logic [7:0] a);
        @(posedge core_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk_in);
        rd <= 1'b0;
        #1;
    endtask
    task automatic wait_loc(input logic [1:0] e);
        for (int i = 0; i < 20 * SC && loc !== e; i++) @(posedge core_clk_in);
        #1;
        check(loc, e);
    endtask
    task automatic cfg(input logic [31:0] d);
        wr32(rca_pkg::OFS_CONFIG, d);
    endtask
    task automatic host_cmd();
        wr32(rca_pkg::OFS_HOST_CMD, 32'h0000_0001);
    endtask
    // held whole samples; sampling may slip a tick
    task automatic pulse(input logic [5:0] a, input int n);
        @(posedge core_clk_in);
        alarm_ev <= a;
        sw_req <= (a != 6'h00);
        repeat (n * SC) @(posedge core_clk_in);
        alarm_ev <= 6'h00;
        sw_req <= 1'b1;
        repeat (4 * SC) @(posedge core_clk_in);
        #1;
    endtask
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            summarize();
        end
    end
    // ==========================================
    // main sequence
    initial begin
        repeat (2) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        rd32(rca_pkg::OFS_CONFIG);
        check(rdata, rca_pkg::CFG_RESET);
        rd32(8'hFC);
        check(rdata, 32'h0000_0000);
        for (int i = 0; i < 20 * SC && valid !== 1'b1; i++) @(posedge core_clk_in);
        check(loc, rca_pkg::RCA_LOC_NONE);
        sel_req <= 1'b1;
        wait_loc(rca_pkg::RCA_LOC_ANALOG);
        for (int r = 0; r < 2; r++) begin
            cfg(32'h0000_3F01 | {30'h0, r[0], 1'b0});
            check(r10, r[0]);
            for (int i = 0; i < 4; i++) begin
                seed = lfsr(seed);
                v = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h7FFF : (i == 2) ? 16'h8000 : seed[15:0];
                setv <= '{voltage: v, current: seed[31:16], power: ~v, resistance: 16'h0000};
                repeat (4 * SC) @(posedge core_clk_in);
                #1;
                check(act.voltage, scale(v, r[0]));
                check(act.current, scale(seed[31:16], r[0]));
                check(act.power, scale(~v, r[0]));
            end
        end
        wr32(rca_pkg::OFS_LIMITS, seed);
        check(limits, seed);
        host_cmd();
        check(host_err, 1'b1);
        cfg(32'h0000_3F00);
        wait_loc(rca_pkg::RCA_LOC_LOCAL);
        host_cmd();
        check(host_err, 1'b1);
        cfg(32'h0000_3F01);
        wait_loc(rca_pkg::RCA_LOC_ANALOG);
        sel_req <= 1'b0;
        wait_loc(rca_pkg::RCA_LOC_NONE);
        host_cmd();
        wait_loc(rca_pkg::RCA_LOC_DIGITAL);
        sel_req <= 1'b1;
        repeat (5 * SC) @(posedge core_clk_in);
        check(loc, rca_pkg::RCA_LOC_DIGITAL);
        sel_req <= 1'b0;
        cfg(32'h0000_3F00);
        wait_loc(rca_pkg::RCA_LOC_LOCAL);
        cfg(32'h0000_3F01);
        repeat (5 * SC) @(posedge core_clk_in);
        check(loc, rca_pkg::RCA_LOC_NONE);
        wr32(rca_pkg::OFS_ACTIVE, 32'h0000_0001);
        check(dc_on, 1'b1);
        pulse(6'h02, 3);
        check(dc_on, 1'b0);
        check(seen, 1'b1);
        pulse(6'h00, 22);
        check(seen, 1'b1);
        pulse(6'h00, 27);
        check(seen, 1'b0);
        pulse(6'h10, 3);
        check(al1, 1'b1);
        pulse(6'h00, 27);
        check(al1, 1'b0);
        cfg(32'h0000_3B05);
        pulse(6'h10, 3);
        check(al1, 1'b0);
        pulse(6'h04, 3);
        check(al2, 1'b0);
        summarize();
    end
endmodule
